// ### verilog/iopcn_params.svh
// offsets, field positions and reset values of the io port / change notify block
`ifndef IOPCN_PARAMS_SVH
`define IOPCN_PARAMS_SVH
`define IOPCN_OFF_DIR 8'h00
`define IOPCN_OFF_LAT 8'h04
`define IOPCN_OFF_ODC 8'h08
`define IOPCN_OFF_ANA 8'h0c
`define IOPCN_OFF_LVL 8'h10
`define IOPCN_OFF_CNEN_LO 8'h14
`define IOPCN_OFF_CNEN_HI 8'h18
`define IOPCN_OFF_PU_LO 8'h1c
`define IOPCN_OFF_PU_HI 8'h20
`define IOPCN_OFF_TMRSEL 8'h24
`define IOPCN_OFF_CNSTAT 8'h28
`define IOPCN_RST_DIR 16'hffff
`define IOPCN_RST_ANA 16'h0000
`define IOPCN_RST_TMRSEL 16'h3f3f
`define IOPCN_TMRSEL_MASK 16'h3f3f
`define IOPCN_T3_LSB 8
`define IOPCN_T2_LSB 0
`define IOPCN_SEL_W 6
`define IOPCN_CN_HI_LSB 16
`define IOPCN_CNSTAT_FLAG 0
`endif

// ### verilog/iopcn_pkg.sv
// types shared by the io port / change notify block
package iopcn_pkg;
    // axi4-lite response codes used by the slave
    typedef enum logic [1:0]
    {
        IOPCN_RESP_OKAY = 2'h0,
        IOPCN_RESP_SLVERR = 2'h2
    } iopcn_resp_t;
endpackage : iopcn_pkg

// ### verilog/iopcn_cn_if.sv
// link between the register side and the change notify detector
`timescale 1ns/100ps
interface iopcn_cn_if #(parameter int CN_PINS = 30);
    logic [CN_PINS-1:0] enable; // per pin notify enable
    logic [CN_PINS-1:0] level; // synchronised pin levels
    logic clear; // one-cycle flag clear request
    logic flag; // shared change flag
    modport regs (output enable, output clear, input level, input flag);
    modport det (input enable, input clear, output level, output flag);
endinterface : iopcn_cn_if

// ### verilog/iopcn_cn_det.sv
// change notify detector: pin synchroniser, reference compare, sticky flag
`timescale 1ns/100ps
module iopcn_cn_det
    import iopcn_pkg::*;
#(
    parameter int CN_PINS = 30
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [CN_PINS-1:0] cn_pin,
    iopcn_cn_if.det cn
);
    logic [CN_PINS-1:0] sync1_reg; // first stage, read only by stage two
    logic [CN_PINS-1:0] sync2_reg; // usable pin level
    logic [CN_PINS-1:0] ref_reg; // level seen last cycle
    logic primed_reg; // reference valid after reset
    logic flag_reg; // sticky change flag
    wire [CN_PINS-1:0] mismatch;
    wire any_change;

    // only enabled pins that differ from their reference count
    assign mismatch = (sync2_reg ^ ref_reg) & cn.enable;
    assign any_change = primed_reg & (|mismatch);
    assign cn.level = sync2_reg;
    assign cn.flag = flag_reg;

    // two-flop synchroniser, pins are asynchronous
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else
        begin
            sync1_reg <= cn_pin;
            sync2_reg <= sync1_reg;
        end
    end

    // level compare, not edge: a change while clocks stop is seen at restart
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ref_reg <= '0;
            primed_reg <= 1'b0;
        end
        else
        begin
            ref_reg <= sync2_reg;
            primed_reg <= 1'b1;
        end
    end

    // shared flag; a new change in the clear cycle wins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            flag_reg <= 1'b0;
        else if (any_change)
            flag_reg <= 1'b1;
        else if (cn.clear)
            flag_reg <= 1'b0;
    end
endmodule : iopcn_cn_det

// ### verilog/iopcn_top.sv
// io port with open drain, analog config, pull-ups and change notification
// What this block does
// - set open-drain bit makes pin open drain
// - analog config resets to zero, all analog
// - analog pins read zero in level register
// - digital input pins are not routed to converter
// - any selected pin change requests an interrupt
// - detection survives stopped clocks
// - up to thirty selectable notify inputs
// - two enable registers, one bit per pin
// - two pull-up registers switch weak pull-ups
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
`include "iopcn_params.svh"
module iopcn_top
    import iopcn_pkg::*;
#(
    parameter int PORT_W = 16,
    parameter int CN_PINS = 30
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [PORT_W-1:0] pin_in,
    output logic [PORT_W-1:0] pin_out,
    output logic [PORT_W-1:0] pin_oe,
    output logic [PORT_W-1:0] adc_route,
    input wire logic [CN_PINS-1:0] change_notify_pin,
    output logic [CN_PINS-1:0] pullup_en,
    output logic cn_irq,
    output logic [5:0] timer3_clock_pin_select,
    output logic [5:0] timer2_clock_pin_select
);
    // byte-lane merge used for every writable register
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] din,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                res[i*8 +: 8] = din[i*8 +: 8];
        return res;
    endfunction : lane_merge

    // register-map decode, shared by read and write paths
    function automatic logic addr_known(input logic [7:0] a);
        return (a <= `IOPCN_OFF_CNSTAT) && (a[1:0] == 2'h0);
    endfunction : addr_known

    iopcn_cn_if #(.CN_PINS(CN_PINS)) cn_link ();

    logic [31:0] dir_reg; // 1 = input
    logic [31:0] lat_reg; // output latch
    logic [31:0] odc_reg; // open drain select
    logic [31:0] ana_reg; // 0 = analog, 1 = digital
    logic [31:0] cnen_reg; // notify enables, low and high halves
    logic [31:0] pu_reg; // pull-up enables, low and high halves
    logic [31:0] tmr_reg; // timer clock pin selects
    logic [PORT_W-1:0] ps1_reg; // pin synchroniser stage one
    logic [PORT_W-1:0] ps2_reg; // pin synchroniser stage two
    // axi state
    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic aw_held_reg, w_held_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    // pin-side outputs, all registered
    logic [PORT_W-1:0] pin_out_reg, pin_oe_reg, adc_route_reg;
    logic [CN_PINS-1:0] pullup_reg;
    logic irq_reg;

    wire aw_hs = s_axi_awvalid & awready_reg;
    wire w_hs = s_axi_wvalid & wready_reg;
    wire ar_hs = s_axi_arvalid & arready_reg;
    wire do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
    wire [31:0] wmerge_dir = lane_merge(dir_reg, wdata_reg, wstrb_reg);
    wire [31:0] wmerge_lat = lane_merge(lat_reg, wdata_reg, wstrb_reg);
    wire [31:0] wmerge_odc = lane_merge(odc_reg, wdata_reg, wstrb_reg);
    wire [31:0] wmerge_ana = lane_merge(ana_reg, wdata_reg, wstrb_reg);
    wire [31:0] wmerge_tmr = lane_merge(tmr_reg, wdata_reg, wstrb_reg);
    wire [31:0] wm_cnlo = lane_merge({16'h0, cnen_reg[15:0]}, wdata_reg, wstrb_reg);
    wire [31:0] wm_cnhi = lane_merge({16'h0, cnen_reg[31:16]}, wdata_reg, wstrb_reg);
    wire [31:0] wm_pulo = lane_merge({16'h0, pu_reg[15:0]}, wdata_reg, wstrb_reg);
    wire [31:0] wm_puhi = lane_merge({16'h0, pu_reg[31:16]}, wdata_reg, wstrb_reg);
    wire [31:0] pmask = {{(32-PORT_W){1'b0}}, {PORT_W{1'b1}}};
    wire [31:0] cmask = {{(32-CN_PINS){1'b0}}, {CN_PINS{1'b1}}};
    // pin level, analog pins forced low whatever the voltage
    wire [31:0] lvl_view = {{(32-PORT_W){1'b0}}, ps2_reg & ana_reg[PORT_W-1:0]};
    wire [31:0] cn_en_m = cnen_reg & cmask;
    wire [31:0] pu_m = pu_reg & cmask;
    wire [31:0] rd_mux =
        (s_axi_araddr == `IOPCN_OFF_DIR) ? dir_reg :
        (s_axi_araddr == `IOPCN_OFF_LAT) ? lat_reg :
        (s_axi_araddr == `IOPCN_OFF_ODC) ? odc_reg :
        (s_axi_araddr == `IOPCN_OFF_ANA) ? ana_reg :
        (s_axi_araddr == `IOPCN_OFF_LVL) ? lvl_view :
        (s_axi_araddr == `IOPCN_OFF_CNEN_LO) ? {16'h0, cn_en_m[15:0]} :
        (s_axi_araddr == `IOPCN_OFF_CNEN_HI) ? {16'h0, cn_en_m[31:16]} :
        (s_axi_araddr == `IOPCN_OFF_PU_LO) ? {16'h0, pu_m[15:0]} :
        (s_axi_araddr == `IOPCN_OFF_PU_HI) ? {16'h0, pu_m[31:16]} :
        (s_axi_araddr == `IOPCN_OFF_TMRSEL) ? tmr_reg :
        (s_axi_araddr == `IOPCN_OFF_CNSTAT) ? {31'h0, cn_link.flag} : 32'h0;
    wire wr_ok = addr_known(awaddr_reg) && (awaddr_reg != `IOPCN_OFF_LVL);
    wire wsel_stat = do_write && (awaddr_reg == `IOPCN_OFF_CNSTAT);

    // flag clear is write-one on bit zero
    assign cn_link.clear = wsel_stat & wstrb_reg[0] & wdata_reg[`IOPCN_CNSTAT_FLAG];
    assign cn_link.enable = cnen_reg[CN_PINS-1:0];

    iopcn_cn_det #(.CN_PINS(CN_PINS)) u_det (
        .aclk(aclk),
        .aresetn(aresetn),
        .cn_pin(change_notify_pin),
        .cn(cn_link.det)
    );

    // write channel: address and data taken in either order, response after both
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= IOPCN_RESP_OKAY;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
        end
        else
        begin
            if (aw_hs)
            begin
                awaddr_reg <= s_axi_awaddr;
                aw_held_reg <= 1'b1;
                awready_reg <= 1'b0;
            end
            if (w_hs)
            begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
                w_held_reg <= 1'b1;
                wready_reg <= 1'b0;
            end
            if (do_write)
            begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_ok ? IOPCN_RESP_OKAY : IOPCN_RESP_SLVERR;
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
            end
            else if (bvalid_reg && s_axi_bready)
            begin
                // reopen both channels only once the response is gone
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    // register updates; level register is read-only and ignores writes
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dir_reg <= {16'h0, `IOPCN_RST_DIR};
            lat_reg <= 32'h0;
            odc_reg <= 32'h0;
            ana_reg <= {16'h0, `IOPCN_RST_ANA};
            cnen_reg <= 32'h0;
            pu_reg <= 32'h0;
            tmr_reg <= {16'h0, `IOPCN_RST_TMRSEL};
        end
        else if (do_write)
        begin
            // port and timer registers keep unused bits at zero; enable and pull-up halves store all 16 bits
            unique case (awaddr_reg)
                `IOPCN_OFF_DIR: dir_reg <= wmerge_dir & pmask;
                `IOPCN_OFF_LAT: lat_reg <= wmerge_lat & pmask;
                `IOPCN_OFF_ODC: odc_reg <= wmerge_odc & pmask;
                `IOPCN_OFF_ANA: ana_reg <= wmerge_ana & pmask;
                `IOPCN_OFF_CNEN_LO: cnen_reg[15:0] <= wm_cnlo[15:0];
                `IOPCN_OFF_CNEN_HI: cnen_reg[31:16] <= wm_cnhi[15:0];
                `IOPCN_OFF_PU_LO: pu_reg[15:0] <= wm_pulo[15:0];
                `IOPCN_OFF_PU_HI: pu_reg[31:16] <= wm_puhi[15:0];
                `IOPCN_OFF_TMRSEL: tmr_reg <= {16'h0, wmerge_tmr[15:0] & `IOPCN_TMRSEL_MASK};
                default: ;
            endcase
        end
    end

    // read channel: one read at a time, data one cycle after address
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= IOPCN_RESP_OKAY;
        end
        else if (ar_hs)
        begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= addr_known(s_axi_araddr) ? IOPCN_RESP_OKAY : IOPCN_RESP_SLVERR;
        end
        else if (rvalid_reg && s_axi_rready)
        begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    // pin synchroniser; stage one feeds stage two only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ps1_reg <= '0;
            ps2_reg <= '0;
        end
        else
        begin
            ps1_reg <= pin_in;
            ps2_reg <= ps1_reg;
        end
    end

    // pin drivers, analog routing, pull-ups and interrupt, all registered
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_out_reg <= '0;
            pin_oe_reg <= '0;
            adc_route_reg <= '0;
            pullup_reg <= '0;
            irq_reg <= 1'b0;
        end
        else
        begin
            // open drain drives low only, releases for a one
            pin_out_reg <= lat_reg[PORT_W-1:0] & ~odc_reg[PORT_W-1:0];
            pin_oe_reg <= ~dir_reg[PORT_W-1:0]
                          & ~(odc_reg[PORT_W-1:0] & lat_reg[PORT_W-1:0]);
            // digital pins never reach the converter, whatever their direction
            adc_route_reg <= ~ana_reg[PORT_W-1:0];
            pullup_reg <= pu_reg[CN_PINS-1:0];
            irq_reg <= cn_link.flag;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign pin_out = pin_out_reg;
    assign pin_oe = pin_oe_reg;
    assign adc_route = adc_route_reg;
    assign pullup_en = pullup_reg;
    assign cn_irq = irq_reg;
    assign timer3_clock_pin_select = tmr_reg[`IOPCN_T3_LSB +: `IOPCN_SEL_W];
    assign timer2_clock_pin_select = tmr_reg[`IOPCN_T2_LSB +: `IOPCN_SEL_W];
endmodule : iopcn_top

// ### dv/iopcn_checker.sv
// port-level assertions for the io port / change notify block
`timescale 1ns/100ps
module iopcn_checker
#(
    parameter int PORT_W = 16,
    parameter int CN_PINS = 30
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [PORT_W-1:0] pin_oe,
    input wire logic [PORT_W-1:0] adc_route,
    input wire logic [CN_PINS-1:0] change_notify_pin,
    input wire logic [CN_PINS-1:0] pullup_en,
    input wire logic cn_irq,
    input wire logic [5:0] timer3_clock_pin_select,
    input wire logic [5:0] timer2_clock_pin_select
);
    logic [CN_PINS-1:0] prev_cn; // last pin sample
    logic [3:0] chg_age; // cycles since a pin moved
    logic [3:0] wr_age; // cycles since a write beat
    // saturating ages bound the waits without long repetitions
    always_ff @(posedge aclk)
    begin
        prev_cn <= change_notify_pin;
        if (!aresetn)
        begin
            chg_age <= 4'hf;
            wr_age <= 4'hf;
        end
        else
        begin
            chg_age <= (change_notify_pin != prev_cn) ? 4'h0 : chg_age + {3'h0, chg_age != 4'hf};
            wr_age <= (s_axi_wvalid && s_axi_wready) ? 4'h0 : wr_age + {3'h0, wr_age != 4'hf};
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence pin_moved_s; chg_age <= 4'h7; endsequence
    sequence write_seen_s; wr_age <= 4'h6; endsequence
    irq_cause_a: assert property ($rose(cn_irq) |-> pin_moved_s)
        else $error("cn_irq rose with no recent pin change");
    irq_sticky_a: assert property ($fell(cn_irq) |-> write_seen_s)
        else $error("cn_irq fell with no status write");
    tmr_reset_a: assert property ($rose(aresetn) |-> timer3_clock_pin_select == 6'h3f
        && timer2_clock_pin_select == 6'h3f)
        else $error("timer selects not all ones after reset");
    ana_reset_a: assert property ($rose(aresetn) |=> adc_route == {PORT_W{1'b1}})
        else $error("pins not analog after reset");
    out_reset_a: assert property ($rose(aresetn) |-> pin_oe == '0 && pullup_en == '0)
        else $error("drive or pull-up on after reset");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_awready ##1 s_axi_bvalid)
        else $error("write answer not two cycles after the take");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer not one cycle later");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped before bready");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer changed before rready");
endmodule : iopcn_checker

bind iopcn_top iopcn_checker #(.PORT_W(PORT_W), .CN_PINS(CN_PINS)) iopcn_checker_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pin_oe(pin_oe), .adc_route(adc_route),
    .change_notify_pin(change_notify_pin), .pullup_en(pullup_en), .cn_irq(cn_irq),
    .timer3_clock_pin_select(timer3_clock_pin_select),
    .timer2_clock_pin_select(timer2_clock_pin_select));

// ### dv/iopcn_pin_model.sv
// external pins and switches facing the io port
`timescale 1ns/100ps
module iopcn_pin_model
#(
    parameter int PORT_W = 16,
    parameter int CN_PINS = 30
)
(
    input wire logic [PORT_W-1:0] pin_out,
    input wire logic [PORT_W-1:0] pin_oe,
    input wire logic [PORT_W-1:0] ext_level,
    input wire logic [CN_PINS-1:0] sw_closed,
    input wire logic [CN_PINS-1:0] sw_level,
    input wire logic [CN_PINS-1:0] pullup_en,
    output logic [PORT_W-1:0] pin_in,
    output logic [CN_PINS-1:0] change_notify_pin
);
    // driven pin shows the port value, a released one the outside level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
    // open switch: pull-up lifts it, else it floats to the inverse level
    assign change_notify_pin = (sw_closed & sw_level)
        | (~sw_closed & (pullup_en | ~sw_level));
endmodule : iopcn_pin_model

// ### dv/iopcn_top_tb.sv
// register-level testbench of the io port / change notify block
`timescale 1ns/100ps
`include "iopcn_params.svh"
module iopcn_top_tb
    import iopcn_pkg::*;
;
    logic aclk, aresetn, clk_run; // clock, reset, clock gate for sleep
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cn_irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] pin_in, pin_out, pin_oe, adc_route, ext_level; // port pins
    logic [29:0] change_notify_pin, pullup_en, sw_closed, sw_level; // notify pins
    logic [5:0] t3_sel, t2_sel;
    int failures, total_checks;
    iopcn_top iopcn_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .adc_route(adc_route), .change_notify_pin(change_notify_pin), .pullup_en(pullup_en),
        .cn_irq(cn_irq), .timer3_clock_pin_select(t3_sel), .timer2_clock_pin_select(t2_sel));
    iopcn_pin_model iopcn_pin_model_inst (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_level(ext_level), .sw_closed(sw_closed), .sw_level(sw_level),
        .pullup_en(pullup_en), .pin_in(pin_in), .change_notify_pin(change_notify_pin));
    // gated clock: a stopped clock stands for sleep
    initial
    begin
        aclk = 1'b0;
        clk_run = 1'b1;
        forever
        begin
            #12.5;
            if (clk_run)
                aclk = ~aclk;
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            $display("BAD %s expected %h seen %h", n, e, g);
            failures++;
        end
    endtask : chk
    // one write: aw, w and bready raised together, each held until taken
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
        logic ad, wd, done;
        logic [1:0] rs;
        {ad, wd, done} = 3'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done)
        begin
            @(posedge aclk);
            if (!ad && s_axi_awready)
                ad = 1'b1;
            if (!wd && s_axi_wready)
                wd = 1'b1;
            s_axi_awvalid <= !ad;
            s_axi_wvalid <= !wd;
            if (s_axi_bvalid && s_axi_bready)
                {rs, done} = {s_axi_bresp, 1'b1};
        end
        s_axi_bready <= 1'b0;
        // one idle edge: the next call never re-drives a strobe in this step
        @(posedge aclk);
        chk("bresp", {30'h0, er}, {30'h0, rs});
    endtask : wr
    // one read, compared against the expected word and response
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
        logic ad, done;
        logic [1:0] rs;
        logic [31:0] got;
        {ad, done} = 2'h0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done)
        begin
            @(posedge aclk);
            if (!ad && s_axi_arready)
                ad = 1'b1;
            s_axi_arvalid <= !ad;
            if (s_axi_rvalid && s_axi_rready)
                {rs, got, done} = {s_axi_rresp, s_axi_rdata, 1'b1};
        end
        s_axi_rready <= 1'b0;
        @(posedge aclk);
        chk("rresp", {30'h0, er}, {30'h0, rs});
        chk("rdata", {16'h0, e}, got);
    endtask : rd
    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
    endtask : idle
    task automatic close_out();
        if (failures == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    // hang guard at 8000 cycles, far beyond the some 125 cycles of the run
    initial
    begin
        #200000;
        failures++;
        close_out();
    end
    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hf};
        {ext_level, sw_closed, sw_level} = {16'ha5a5, 30'h3fffffff, 30'h0};
        {failures, total_checks} = 0;
        idle(4);
        aresetn <= 1'b1;
        idle(2);
        chk("tsel", 32'h3f3f, {18'h0, t3_sel, 2'h0, t2_sel});
        chk("adc_route", 32'hffff, {16'h0, adc_route});
        rd(`IOPCN_OFF_ANA, 16'h0000, IOPCN_RESP_OKAY);
        rd(`IOPCN_OFF_LVL, 16'h0000, IOPCN_RESP_OKAY);
        rd(8'h2c, 16'h0, IOPCN_RESP_SLVERR);
        wr(`IOPCN_OFF_LVL, 16'hffff, IOPCN_RESP_SLVERR);
        wr(`IOPCN_OFF_TMRSEL, 16'hffff, IOPCN_RESP_OKAY);
        rd(`IOPCN_OFF_TMRSEL, 16'h3f3f, IOPCN_RESP_OKAY);
        wr(`IOPCN_OFF_TMRSEL, 16'h1234, IOPCN_RESP_OKAY);
        chk("tsel", 32'h1234, {18'h0, t3_sel, 2'h0, t2_sel});
        // analog pins stay inputs as direction resets to input
        wr(`IOPCN_OFF_ANA, 16'h00ff, IOPCN_RESP_OKAY);
        idle(2);
        rd(`IOPCN_OFF_LVL, 16'h00a5, IOPCN_RESP_OKAY);
        chk("adc_route", 32'hff00, {16'h0, adc_route});
        // outputs with open drain on pins 4,5; pull-ups stay off meanwhile
        wr(`IOPCN_OFF_ANA, 16'hffff, IOPCN_RESP_OKAY);
        wr(`IOPCN_OFF_LAT, 16'h00f0, IOPCN_RESP_OKAY);
        wr(`IOPCN_OFF_ODC, 16'h0030, IOPCN_RESP_OKAY);
        wr(`IOPCN_OFF_DIR, 16'h0000, IOPCN_RESP_OKAY);
        idle(2);
        chk("pin_oe", 32'hffcf, {16'h0, pin_oe});
        chk("pin_out", 32'h00c0, {16'h0, pin_out});
        rd(`IOPCN_OFF_LVL, 16'h00e0, IOPCN_RESP_OKAY);
        // back to inputs before any pull-up goes on
        wr(`IOPCN_OFF_DIR, 16'hffff, IOPCN_RESP_OKAY);
        wr(`IOPCN_OFF_PU_LO, 16'h1235, IOPCN_RESP_OKAY);
        wr(`IOPCN_OFF_PU_HI, 16'hffff, IOPCN_RESP_OKAY);
        chk("pullup_en", 32'h3fff1235, {2'h0, pullup_en});
        // notify on pins 0 and 17 only
        wr(`IOPCN_OFF_CNEN_LO, 16'h0001, IOPCN_RESP_OKAY);
        wr(`IOPCN_OFF_CNEN_HI, 16'h0002, IOPCN_RESP_OKAY);
        sw_level <= 30'h2;
        idle(8);
        chk("cn_irq", 32'h0, {31'h0, cn_irq});
        sw_level <= 30'h20002;
        idle(8);
        chk("cn_irq", 32'h1, {31'h0, cn_irq});
        rd(`IOPCN_OFF_CNSTAT, 16'h0001, IOPCN_RESP_OKAY);
        wr(`IOPCN_OFF_CNSTAT, 16'h0001, IOPCN_RESP_OKAY);
        idle(4);
        chk("cn_irq", 32'h0, {31'h0, cn_irq});
        rd(`IOPCN_OFF_CNSTAT, 16'h0000, IOPCN_RESP_OKAY);
        // sleep: clock stops, switch 0 opens and its pull-up lifts the pin
        clk_run = 1'b0;
        #100 sw_closed = 30'h3ffffffe;
        #100 clk_run = 1'b1;
        idle(8);
        chk("cn_irq", 32'h1, {31'h0, cn_irq});
        close_out();
    end
endmodule : iopcn_top_tb
